//--- verilog/epsh_pkg.sv
package epsh_pkg;
    typedef logic [5:0] epsh_x_t;
    typedef logic [8:0] epsh_y_t;
    typedef logic [7:0] epsh_byte_t;

    // command codes
    localparam epsh_byte_t CMD_WR_BW = 8'h24;
    localparam epsh_byte_t CMD_WR_RED = 8'h26;
    localparam epsh_byte_t CMD_RD_RAM = 8'h27;
    localparam epsh_byte_t CMD_RD_OPT = 8'h41;
    localparam epsh_byte_t CMD_X_WIN = 8'h44;
    localparam epsh_byte_t CMD_Y_WIN = 8'h45;
    localparam epsh_byte_t CMD_FILL_RED = 8'h46;
    localparam epsh_byte_t CMD_FILL_BW = 8'h47;
    localparam epsh_byte_t CMD_X_CNT = 8'h4e;
    localparam epsh_byte_t CMD_Y_CNT = 8'h4f;
    localparam epsh_byte_t CMD_NOP = 8'h7f;
    localparam epsh_byte_t CMD_RD_1B = 8'h1b;
    localparam epsh_byte_t CMD_RD_2D = 8'h2d;
    localparam epsh_byte_t CMD_USER_ID = 8'h2e;
    localparam epsh_byte_t CMD_STATUS = 8'h2f;
    localparam epsh_byte_t CMD_CRC = 8'h35;

    // reset values
    localparam epsh_x_t X_START_RST = 6'h00;
    localparam epsh_x_t X_END_RST = 6'h15;
    localparam epsh_y_t Y_START_RST = 9'h000;
    localparam epsh_y_t Y_END_RST = 9'h127;
    localparam epsh_x_t X_CNT_RST = 6'h00;
    localparam epsh_y_t Y_CNT_RST = 9'h000;
    localparam epsh_byte_t DUMMY_BYTE = 8'h00;
    // arbitrary identification value
    localparam logic [1:0] CHIP_ID = 2'h2;
    localparam int STAT_BUSY_BIT = 2;

    // parameter byte fields
    localparam int FIRST_BIT = 7;
    localparam int HEIGHT_LSB = 4;
    localparam int WIDTH_LSB = 0;
    localparam int OPT_RED_BIT = 0;

    // display ram geometry in bytes
    localparam int RAM_COLS = 25;
    localparam int RAM_ROWS = 200;
    localparam int RAM_DEPTH = RAM_COLS * RAM_ROWS;

    // link framing
    localparam logic [3:0] BITS_4W = 4'h8;
    localparam logic [3:0] BITS_3W = 4'h9;

    // host timing, core clock 20 MHz
    localparam int CLK_NS = 50;
    localparam int SCLK_DIV = 8;
    localparam int SCLK_HALF = SCLK_DIV / 2;
    localparam int T_CSSU_NS = 100;
    localparam int T_CSHLD_NS = 65;
    localparam int T_CSHIGH_NS = 250;
    localparam int CSSU_CYC = (T_CSSU_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSHLD_CYC = (T_CSHLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSHIGH_CYC = (T_CSHIGH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum {HS_IDLE, HS_SETUP, HS_BIT, HS_HOLD, HS_GAP} epsh_hst_t;

    // step length for 3-bit height/width codes: 8..128, then 200
    function automatic epsh_byte_t epsh_step_len(input logic [2:0] code);
        case (code)
            3'h0: epsh_step_len = 8'h08;
            3'h1: epsh_step_len = 8'h10;
            3'h2: epsh_step_len = 8'h20;
            3'h3: epsh_step_len = 8'h40;
            3'h4: epsh_step_len = 8'h80;
            default: epsh_step_len = 8'hc8;
        endcase
    endfunction
endpackage

//--- verilog/epsh_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface epsh_link_if;
    logic sclk;
    logic cs_n;
    logic dc;
    logic hw_reset_n;
    logic link_type_strap;
    logic busy;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;

    // released line reads high
    assign sda = sda_dev_oe ? sda_dev_o : (sda_host_oe ? sda_host_o : 1'b1);

    modport device(input sclk, cs_n, dc, hw_reset_n, link_type_strap, sda,
                   output busy, sda_dev_o, sda_dev_oe);
    modport host(output sclk, cs_n, dc, hw_reset_n, link_type_strap, sda_host_o, sda_host_oe,
                 input sda, busy);
endinterface
`default_nettype wire

//--- verilog/epsh_pattern_fill.sv
`timescale 1ns/1ps
`default_nettype none
module epsh_pattern_fill (
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset
    input wire logic start, // start pulse
    input wire logic to_bw, // 1: black/white ram, 0: red ram
    input wire epsh_pkg::epsh_byte_t param, // pattern parameter
    output logic busy, // fill running
    output logic we, // write strobe
    output logic tgt_bw, // target of write
    output logic [12:0] addr, // byte address
    output epsh_pkg::epsh_byte_t data // byte to write
);
    import epsh_pkg::*;
    logic busy_q, busy_d, bw_q, bw_d, first_q, first_d, yph_q, yph_d, xph_q, xph_d;
    logic we_q, we_d;
    logic [4:0] x_q, x_d, wcnt_q, wcnt_d, wlen_q, wlen_d;
    logic [7:0] y_q, y_d, hcnt_q, hcnt_d, hlen_q, hlen_d, data_q, data_d;
    logic [12:0] addr_q, addr_d;
    epsh_byte_t wsteps;

    assign wsteps = epsh_step_len(param[WIDTH_LSB +: 3]);

    always_comb begin
        {busy_d, bw_d, first_d, yph_d, xph_d} = {busy_q, bw_q, first_q, yph_q, xph_q};
        {x_d, wcnt_d, wlen_d, y_d, hcnt_d, hlen_d} = {x_q, wcnt_q, wlen_q, y_q, hcnt_q, hlen_q};
        addr_d = addr_q;
        we_d = 1'b0;
        data_d = data_q;
        if (busy_q) begin
            we_d = 1'b1;
            addr_d = addr_q + 13'h1;
            // whole byte shares one value, steps are multiples of 8 pixels
            data_d = {8{first_q ^ yph_q ^ (bw_q & xph_q)}};
            if (x_q == 5'(RAM_COLS - 1)) begin
                x_d = 5'h0;
                wcnt_d = 5'h0;
                xph_d = 1'b0;
                y_d = y_q + 8'h1;
                hcnt_d = (hcnt_q == hlen_q - 8'h1) ? 8'h0 : hcnt_q + 8'h1;
                yph_d = yph_q ^ (hcnt_q == hlen_q - 8'h1);
                busy_d = (y_q != 8'(RAM_ROWS - 1));
            end else begin
                x_d = x_q + 5'h1;
                wcnt_d = (wcnt_q == wlen_q - 5'h1) ? 5'h0 : wcnt_q + 5'h1;
                xph_d = xph_q ^ (wcnt_q == wlen_q - 5'h1);
            end
        end else if (start) begin
            busy_d = 1'b1;
            bw_d = to_bw;
            first_d = param[FIRST_BIT];
            hlen_d = epsh_step_len(param[HEIGHT_LSB +: 3]);
            wlen_d = wsteps[7:3];
            {x_d, wcnt_d, y_d, hcnt_d, yph_d, xph_d} = '0;
            addr_d = 13'h1fff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {busy_q, bw_q, first_q, yph_q, xph_q, we_q} <= '0;
            {x_q, wcnt_q, wlen_q, y_q, hcnt_q, hlen_q} <= '0;
            addr_q <= 13'h0;
            data_q <= 8'h00;
        end else begin
            {busy_q, bw_q, first_q, yph_q, xph_q, we_q} <= {busy_d, bw_d, first_d, yph_d, xph_d, we_d};
            {x_q, wcnt_q, wlen_q, y_q, hcnt_q, hlen_q} <= {x_d, wcnt_d, wlen_d, y_d, hcnt_d, hlen_d};
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    // busy covers the last write still in flight
    assign busy = busy_q | we_q;
    assign we = we_q;
    assign tgt_bw = bw_q;
    assign addr = addr_q;
    assign data = data_q;
endmodule
`default_nettype wire

//--- verilog/epsh_device.sv
`timescale 1ns/1ps
`default_nettype none
module epsh_device (
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset
    epsh_link_if.device link, // serial host link
    output epsh_pkg::epsh_x_t x_window_start, // x window start
    output epsh_pkg::epsh_x_t x_window_end, // x window end
    output epsh_pkg::epsh_y_t y_window_start, // y window start
    output epsh_pkg::epsh_y_t y_window_end, // y window end
    output epsh_pkg::epsh_x_t ram_address_counter_x, // x address counter
    output epsh_pkg::epsh_y_t ram_address_counter_y, // y address counter
    output logic read_red, // ram read selects red ram
    output logic fill_busy // pattern fill running
);
    import epsh_pkg::*;
    logic rst_n, frame_rst_n, mode3, last_bit, load, fbusy;
    assign rst_n = arst_n & link.hw_reset_n;
    // frame state ends with chip select, since sclk stops between frames
    assign frame_rst_n = rst_n & ~link.cs_n;

    // ---------------- link domain ----------------
    logic [1:0] strap_s_q, strap_s_d, busy_s_q, busy_s_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, full, rcmd_q, rcmd_d, byte_q, byte_d, out_q, out_d, nxt;
    logic rd_q, rd_d, first_q, first_d, dc_q, dc_d, btog_q, btog_d, rtog_q, rtog_d, oe_q, oe_d;
    logic is_rd;
    epsh_byte_t rdata_q;

    assign mode3 = strap_s_q[1];
    assign last_bit = (cnt_q == ((mode3 ? BITS_3W : BITS_4W) - 4'h1));
    assign full = {sh_q[6:0], link.sda};
    assign is_rd = (full == CMD_RD_RAM) || (full == CMD_STATUS) || (full == CMD_USER_ID)
                 || (full == CMD_CRC) || (full == CMD_RD_1B) || (full == CMD_RD_2D);

    always_comb begin
        strap_s_d = {strap_s_q[0], link.link_type_strap};
        busy_s_d = {busy_s_q[0], fbusy};
        cnt_d = cnt_q + 4'h1;
        sh_d = full;
        {rd_d, first_d, rcmd_d} = {rd_q, first_q, rcmd_q};
        {byte_d, dc_d, btog_d} = {byte_q, dc_q, btog_q};
        if (last_bit) begin
            cnt_d = 4'h0;
            if (rd_q) begin
                first_d = 1'b0;
            end else begin
                byte_d = full;
                // three-wire: select pin ignored, flag comes first
                dc_d = mode3 ? sh_q[7] : link.dc;
                btog_d = ~btog_q;
                if (!dc_d && is_rd) begin
                    rd_d = 1'b1;
                    first_d = 1'b1;
                    rcmd_d = full;
                end
            end
        end
    end

    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            {rd_q, first_q} <= 2'b00;
            rcmd_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            {rd_q, first_q} <= {rd_d, first_d};
            rcmd_q <= rcmd_d;
        end
    end

    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            {strap_s_q, busy_s_q} <= 4'h0;
            {byte_q, dc_q, btog_q} <= '0;
        end else begin
            {strap_s_q, busy_s_q} <= {strap_s_d, busy_s_d};
            {byte_q, dc_q, btog_q} <= {byte_d, dc_d, btog_d};
        end
    end

    // output side on falling edges; three-wire skips the host flag bit
    assign load = rd_q && (cnt_q == (mode3 ? 4'h1 : 4'h0));
    assign nxt = (rcmd_q == CMD_STATUS) ? {5'h0, busy_s_q[1], CHIP_ID}
               : (first_q || rcmd_q != CMD_RD_RAM) ? DUMMY_BYTE : rdata_q;
    assign out_d = load ? nxt : {out_q[6:0], 1'b0};
    assign oe_d = rd_q && (!mode3 || cnt_q != 4'h0);
    // asking for the next word at load leaves a whole byte for the core
    assign rtog_d = (load && !first_q) ? ~rtog_q : rtog_q;

    always_ff @(negedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            rtog_q <= 1'b0;
        end else begin
            rtog_q <= rtog_d;
        end
    end

    assign link.sda_dev_o = out_q[7];
    assign link.sda_dev_oe = oe_q;

    // ---------------- core domain ----------------
    logic [2:0] bsync_q, bsync_d, rsync_q, rsync_d;
    logic [1:0] pidx_q, pidx_d;
    logic byte_ev, rd_ev, adv, fetch, in_range, rd_red_q, rd_red_d, bw_we, red_we, hwe_bw, hwe_red;
    logic fill_start, fill_to_bw, f_we, f_bw;
    logic [12:0] addr, f_addr, wa;
    epsh_byte_t cmd_q, cmd_d, rdata_d, f_data, wd;
    epsh_x_t xws_q, xws_d, xwe_q, xwe_d, xc_q, xc_d, nx;
    epsh_y_t yws_q, yws_d, ywe_q, ywe_d, yc_q, yc_d, ny;
    logic [7:0] bw_mem [RAM_DEPTH];
    logic [7:0] red_mem [RAM_DEPTH];

    assign byte_ev = bsync_q[1] ^ bsync_q[2];
    assign rd_ev = rsync_q[1] ^ rsync_q[2];
    assign addr = 13'(yc_q) * 13'(RAM_COLS) + 13'(xc_q);
    assign in_range = (yc_q < 9'(RAM_ROWS)) && (xc_q < 6'(RAM_COLS));
    assign nx = (xc_q == xwe_q) ? xws_q : xc_q + 6'h1;
    assign ny = (xc_q != xwe_q) ? yc_q : ((yc_q == ywe_q) ? yws_q : yc_q + 9'h1);

    always_comb begin
        bsync_d = {bsync_q[1:0], btog_q};
        rsync_d = {rsync_q[1:0], rtog_q};
        {cmd_d, pidx_d, rd_red_d} = {cmd_q, pidx_q, rd_red_q};
        {xws_d, xwe_d, yws_d, ywe_d, xc_d, yc_d} = {xws_q, xwe_q, yws_q, ywe_q, xc_q, yc_q};
        {adv, fetch, hwe_bw, hwe_red, fill_start, fill_to_bw} = '0;
        if (byte_ev && !dc_q) begin
            cmd_d = byte_q;
            pidx_d = 2'h0;
            fetch = (byte_q == CMD_RD_RAM);
        end else if (byte_ev) begin
            pidx_d = (pidx_q == 2'h3) ? pidx_q : pidx_q + 2'h1;
            case (cmd_q)
                CMD_X_WIN: begin
                    if (pidx_q == 2'h0) xws_d = byte_q[5:0];
                    if (pidx_q == 2'h1) xwe_d = byte_q[5:0];
                end
                CMD_Y_WIN: begin
                    case (pidx_q)
                        2'h0: yws_d = {yws_q[8], byte_q};
                        2'h1: yws_d = {byte_q[0], yws_q[7:0]};
                        2'h2: ywe_d = {ywe_q[8], byte_q};
                        default: ywe_d = {byte_q[0], ywe_q[7:0]};
                    endcase
                end
                CMD_X_CNT: begin
                    if (pidx_q == 2'h0) xc_d = byte_q[5:0];
                end
                CMD_Y_CNT: begin
                    if (pidx_q == 2'h0) yc_d = {yc_q[8], byte_q};
                    if (pidx_q == 2'h1) yc_d = {byte_q[0], yc_q[7:0]};
                end
                CMD_RD_OPT: rd_red_d = byte_q[OPT_RED_BIT];
                CMD_FILL_RED: fill_start = (pidx_q == 2'h0);
                CMD_FILL_BW: begin
                    fill_start = (pidx_q == 2'h0);
                    fill_to_bw = 1'b1;
                end
                CMD_WR_BW: begin
                    hwe_bw = in_range;
                    adv = 1'b1;
                end
                CMD_WR_RED: begin
                    hwe_red = in_range;
                    adv = 1'b1;
                end
                default: ;
            endcase
        end else if (rd_ev && cmd_q == CMD_RD_RAM) begin
            fetch = 1'b1;
        end
        rdata_d = rdata_q;
        if (fetch) begin
            rdata_d = !in_range ? 8'h00 : (rd_red_q ? red_mem[addr] : bw_mem[addr]);
            adv = 1'b1;
        end
        if (adv) begin
            xc_d = nx;
            yc_d = ny;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {bsync_q, rsync_q} <= 6'h0;
            cmd_q <= CMD_NOP;
            pidx_q <= 2'h0;
            rd_red_q <= 1'b0;
            rdata_q <= 8'h00;
            {xws_q, xwe_q, yws_q, ywe_q} <= {X_START_RST, X_END_RST, Y_START_RST, Y_END_RST};
            {xc_q, yc_q} <= {X_CNT_RST, Y_CNT_RST};
        end else begin
            {bsync_q, rsync_q} <= {bsync_d, rsync_d};
            cmd_q <= cmd_d;
            pidx_q <= pidx_d;
            rd_red_q <= rd_red_d;
            rdata_q <= rdata_d;
            {xws_q, xwe_q, yws_q, ywe_q} <= {xws_d, xwe_d, yws_d, ywe_d};
            {xc_q, yc_q} <= {xc_d, yc_d};
        end
    end

    epsh_pattern_fill u_fill (
        .clk(clk),
        .arst_n(rst_n),
        .start(fill_start),
        .to_bw(fill_to_bw),
        .param(byte_q),
        .busy(fbusy),
        .we(f_we),
        .tgt_bw(f_bw),
        .addr(f_addr),
        .data(f_data)
    );

    // host writes are dropped while a fill owns the ram
    assign bw_we = f_we ? f_bw : (hwe_bw & ~fbusy);
    assign red_we = f_we ? ~f_bw : (hwe_red & ~fbusy);
    assign wa = f_we ? f_addr : addr;
    assign wd = f_we ? f_data : byte_q;

    always_ff @(posedge clk) begin
        if (bw_we) bw_mem[wa] <= wd;
        if (red_we) red_mem[wa] <= wd;
    end

    assign link.busy = fbusy;
    assign fill_busy = fbusy;
    assign {x_window_start, x_window_end, y_window_start, y_window_end} = {xws_q, xwe_q, yws_q, ywe_q};
    assign {ram_address_counter_x, ram_address_counter_y} = {xc_q, yc_q};
    assign read_red = rd_red_q;
endmodule
`default_nettype wire

//--- verilog/epsh_host.sv
`timescale 1ns/1ps
`default_nettype none
module epsh_host (
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset
    epsh_link_if.host link, // serial link to panel
    input wire logic link_type_strap, // 0 four-wire, 1 three-wire
    input wire logic panel_reset, // hold panel in reset
    input wire logic req_valid, // unit request
    output logic req_ready, // request taken
    input wire logic req_dc, // 0 command, 1 data
    input wire logic req_read, // unit is a read byte
    input wire logic req_last, // release chip select after unit
    input wire epsh_pkg::epsh_byte_t req_byte, // byte to send
    output logic rsp_valid, // read byte ready, one cycle
    output epsh_pkg::epsh_byte_t rsp_byte, // read byte
    output logic panel_busy // synchronised busy pin
);
    import epsh_pkg::*;
    epsh_hst_t st_q, st_d;
    logic [2:0] ph_q, ph_d, wt_q, wt_d;
    logic [3:0] bit_q, bit_d, nb_q, nb_d;
    logic [8:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d, rsp_q, rsp_d;
    logic [1:0] sda_s_q, busy_s_q;
    logic cs_n_q, cs_n_d, sclk_q, sclk_d, sdo_q, sdo_d, oe_q, oe_d, dc_q, dc_d;
    logic rd_q, rd_d, last_q, last_d, rv_q, rv_d, strap_q, rstn_q;

    assign req_ready = (st_q == HS_IDLE);

    always_comb begin
        st_d = st_q;
        {ph_d, wt_d, bit_d, nb_d, sh_d, rx_d, rsp_d} = {ph_q, wt_q, bit_q, nb_q, sh_q, rx_q, rsp_q};
        {cs_n_d, sclk_d, sdo_d, oe_d, dc_d, rd_d, last_d} = {cs_n_q, sclk_q, sdo_q, oe_q, dc_q, rd_q, last_q};
        rv_d = 1'b0;
        case (st_q)
            HS_IDLE: begin
                if (req_valid) begin
                    // three-wire: flag bit leads, select pin held low
                    sh_d = strap_q ? {req_dc | req_read, req_byte} : {req_byte, 1'b0};
                    nb_d = (strap_q ? BITS_3W : BITS_4W) - 4'h1;
                    dc_d = strap_q ? 1'b0 : (req_dc | req_read);
                    {rd_d, last_d} = {req_read, req_last};
                    {ph_d, bit_d, wt_d} = '0;
                    cs_n_d = 1'b0;
                    st_d = cs_n_q ? HS_SETUP : HS_BIT;
                end
            end
            HS_SETUP: begin
                wt_d = wt_q + 3'h1;
                if (wt_q == 3'(CSSU_CYC - 1)) st_d = HS_BIT;
            end
            HS_BIT: begin
                ph_d = ph_q + 3'h1;
                if (ph_q == 3'h0) begin
                    sdo_d = sh_q[8];
                    oe_d = !rd_q || (strap_q && bit_q == 4'h0);
                end
                if (ph_q == 3'(SCLK_HALF - 1)) sclk_d = 1'b1;
                if (ph_q == 3'(SCLK_DIV - 1)) begin
                    sclk_d = 1'b0;
                    // device starts driving at this fall, so the read flag lets go here
                    if (rd_q) oe_d = 1'b0;
                    sh_d = {sh_q[7:0], 1'b0};
                    rx_d = {rx_q[6:0], sda_s_q[1]};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == nb_q) begin
                        oe_d = 1'b0;
                        rv_d = rd_q;
                        rsp_d = rd_q ? {rx_q[6:0], sda_s_q[1]} : rsp_q;
                        wt_d = 3'h0;
                        st_d = last_q ? HS_HOLD : HS_IDLE;
                    end
                end
            end
            HS_HOLD: begin
                wt_d = wt_q + 3'h1;
                if (wt_q == 3'(CSHLD_CYC - 1)) begin
                    cs_n_d = 1'b1;
                    wt_d = 3'h0;
                    st_d = HS_GAP;
                end
            end
            HS_GAP: begin
                wt_d = wt_q + 3'h1;
                if (wt_q == 3'(CSHIGH_CYC - 1)) st_d = HS_IDLE;
            end
            default: st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= HS_IDLE;
            {ph_q, wt_q, bit_q, nb_q, sh_q, rx_q, rsp_q} <= '0;
            {sclk_q, sdo_q, oe_q, dc_q, rd_q, last_q, rv_q} <= '0;
            cs_n_q <= 1'b1;
            {sda_s_q, busy_s_q} <= 4'h0;
            {strap_q, rstn_q} <= 2'b00;
        end else begin
            st_q <= st_d;
            {ph_q, wt_q, bit_q, nb_q, sh_q, rx_q, rsp_q} <= {ph_d, wt_d, bit_d, nb_d, sh_d, rx_d, rsp_d};
            {sclk_q, sdo_q, oe_q, dc_q, rd_q, last_q, rv_q} <= {sclk_d, sdo_d, oe_d, dc_d, rd_d, last_d, rv_d};
            cs_n_q <= cs_n_d;
            sda_s_q <= {sda_s_q[0], link.sda};
            busy_s_q <= {busy_s_q[0], link.busy};
            strap_q <= link_type_strap;
            rstn_q <= ~panel_reset;
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.dc = dc_q;
    assign link.sda_host_o = sdo_q;
    assign link.sda_host_oe = oe_q;
    assign link.link_type_strap = strap_q;
    assign link.hw_reset_n = rstn_q;
    assign rsp_valid = rv_q;
    assign rsp_byte = rsp_q;
    assign panel_busy = busy_s_q[1];
endmodule
`default_nettype wire

//--- bench/epsh_checker.sv
`timescale 1ns/1ps
`default_nettype none
module epsh_checker (
    input wire logic clk, // core clock
    input wire logic arst_n, // reset
    input wire logic sclk, // link clock
    input wire logic cs_n, // select
    input wire logic dc, // data/command
    input wire logic link_type_strap, // mode
    input wire logic busy, // fill busy
    input wire logic sda_host_oe, // host drives
    input wire logic sda_dev_o, // device data
    input wire logic sda_dev_oe // device drives
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // fill length, bounded a little above 5000
    logic [12:0] n_q, n_d;
    always_comb n_d = busy ? n_q + 13'h1 : 13'h0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) n_q <= 13'h0;
        else n_q <= n_d;
    end
    a_idle_no_drive: assert property (cs_n [*2] |-> !sda_dev_oe) else $error("device drives idle");
    a_one_driver: assert property (!(sda_dev_oe && sda_host_oe)) else $error("data line clash");
    a_dc_tied: assert property (link_type_strap && !cs_n |-> !dc) else $error("select not low");
    a_dc_steady: assert property (sclk && $past(sclk) |-> $stable(dc)) else $error("select moved");
    a_clock_idle: assert property (cs_n |-> !sclk) else $error("clock runs idle");
    a_out_on_fall: assert property (sda_dev_oe && $past(sda_dev_oe) && $changed(sda_dev_o) |-> $fell(sclk))
        else $error("read bit moved off falling edge");
    a_fill_busy: assert property ($rose(busy) |-> busy [*8]) else $error("busy too short");
    a_fill_len: assert property (busy |-> n_q < 13'h1392) else $error("fill too long");
endmodule
`default_nettype wire

//--- bench/epaper_serial_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module epaper_serial_host_port_tb;
    import epsh_pkg::*;
    typedef struct {logic s; epsh_byte_t c; logic [31:0] p; int np; int sel; logic [8:0] e;} epsh_row_t;
    logic clk, arst_n, strap, req_valid, req_ready, req_dc, req_read, req_last, rsp_valid, rr, fb, pb;
    epsh_byte_t req_byte, rsp_byte, v;
    epsh_byte_t got [3];
    epsh_x_t xs, xe, cx;
    epsh_y_t ys, ye, cy;
    logic [8:0] obs [7];
    int err_total, n_tests, cyc;
    epsh_row_t rows [8] = '{'{0, CMD_X_WIN, 32'h03120000, 2, 1, 9'h012}, '{1, CMD_X_WIN, 32'h05100000, 2, 0, 9'h005},
        '{0, CMD_Y_WIN, 32'h20011001, 4, 3, 9'h110}, '{1, CMD_Y_WIN, 32'h34004500, 4, 2, 9'h034},
        '{0, CMD_X_CNT, 32'h07000000, 1, 4, 9'h007}, '{1, CMD_Y_CNT, 32'h2a010000, 2, 5, 9'h12a},
        '{0, CMD_RD_OPT, 32'h01000000, 1, 6, 9'h001}, '{1, CMD_NOP, 32'h0, 0, 5, 9'h12a}};
    always_comb obs = '{9'(xs), 9'(xe), ys, ye, 9'(cx), cy, 9'(rr)};
    epsh_link_if lnk ();
    epsh_device epsh_device_inst (.clk(clk), .arst_n(arst_n), .link(lnk.device), .x_window_start(xs),
        .x_window_end(xe), .y_window_start(ys), .y_window_end(ye), .ram_address_counter_x(cx),
        .ram_address_counter_y(cy), .read_red(rr), .fill_busy(fb));
    epsh_host epsh_host_inst (.clk(clk), .arst_n(arst_n), .link(lnk.host), .link_type_strap(strap),
        .panel_reset(1'b0), .req_valid(req_valid), .req_ready(req_ready), .req_dc(req_dc), .req_read(req_read),
        .req_last(req_last), .req_byte(req_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .panel_busy(pb));
    epsh_checker epsh_checker_inst (.clk(clk), .arst_n(arst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .dc(lnk.dc),
        .link_type_strap(lnk.link_type_strap), .busy(lnk.busy), .sda_host_oe(lnk.sda_host_oe),
        .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe));
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // request held until taken at a rising edge with ready high
    task automatic send(input logic d, input logic r, input logic l, input epsh_byte_t b);
        @(posedge clk);
        req_valid <= 1'b1;
        req_dc <= d;
        req_read <= r;
        req_last <= l;
        req_byte <= b;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        if (r) begin
            @(negedge clk);
            while (rsp_valid !== 1'b1) @(negedge clk);
            v = rsp_byte;
        end
    endtask
    task automatic frame(input logic s, input epsh_byte_t c, input int np, input logic [31:0] p, input int nr);
        @(posedge clk);
        strap <= s;
        repeat (3) @(posedge clk);
        send(1'b0, 1'b0, np + nr == 0, c);
        for (int i = 0; i < np; i++) send(1'b1, 1'b0, i == np - 1 && nr == 0, p[31 - 8 * i -: 8]);
        for (int i = 0; i < nr; i++) begin
            send(1'b1, 1'b1, i == nr - 1, 8'h00);
            got[i] = v;
        end
        // let the last byte cross into the core
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        repeat (8) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        {arst_n, strap, req_valid, req_dc, req_read, req_last, req_byte, err_total, n_tests, cyc} = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("reset", {6'h00, 6'h15, 9'h000, 9'h127, 6'h00, 9'h000}, {xs, xe, ys, ye, cx, cy});
        foreach (rows[i]) begin
            frame(rows[i].s, rows[i].c, rows[i].np, rows[i].p, 0);
            chk("row", rows[i].e, obs[rows[i].sel]);
            $display("test row %0d done", i);
        end
        for (int s = 0; s < 2; s++) begin
            frame(s[0], CMD_STATUS, 0, 0, 1);
            chk("status", {5'h00, 1'b0, CHIP_ID}, got[0]);
        end
        $display("test status done");
        frame(1'b0, CMD_X_CNT, 1, 32'h02000000, 0);
        frame(1'b0, CMD_Y_CNT, 2, 32'h03000000, 0);
        frame(1'b0, CMD_WR_BW, 2, 32'ha53c0000, 0);
        frame(1'b0, CMD_RD_OPT, 1, 0, 0);
        frame(1'b0, CMD_X_CNT, 1, 32'h02000000, 0);
        frame(1'b1, CMD_RD_RAM, 0, 0, 3);
        chk("ram", 24'h00a53c, {got[0], got[1], got[2]});
        $display("test ram done");
        for (int k = 0; k < 2; k++) begin
            frame(1'b0, k ? CMD_FILL_BW : CMD_FILL_RED, 1, 32'h80000000, 0);
            chk("busy", 1, fb);
            chk("panel busy", 1, pb);
            while (fb !== 1'b0) @(negedge clk);
            frame(1'b0, CMD_RD_OPT, 1, {7'h00, !k[0], 24'h0}, 0);
            frame(1'b0, CMD_X_CNT, 1, 0, 0);
            frame(1'b0, CMD_Y_CNT, 2, 0, 0);
            frame(1'b0, CMD_RD_RAM, 0, 0, 2);
            chk("fill", 8'hff, got[1]);
            $display("test fill %0d done", k);
        end
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("rerun", {6'h00, 6'h15, 9'h000, 9'h127, 6'h00, 9'h000, 1'b0}, {xs, xe, ys, ye, cx, cy, rr});
        $display("test reset done");
        complete_run();
    end
endmodule
`default_nettype wire
